// ===== src/ugc_regs.svh
`ifndef UGC_REGS_SVH
`define UGC_REGS_SVH

// ****************************************
// timing
// ****************************************
`define UGC_CLK_MHZ          8'h7D
`define UGC_NS_PER_US        32'h3E8
`define UGC_TB_PERIOD_NS     32'h64
`define UGC_HR_PERIOD_NS     32'hA
`define UGC_DITHER           8'h01

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define UGC_ADDR_CTRL        8'h00
`define UGC_ADDR_STATUS      8'h04
`define UGC_ADDR_DISPLAY     8'h08
`define UGC_ADDR_ACCUM       8'h0C
`define UGC_ADDR_DPOINT      8'h10

// ****************************************
// fields
// ****************************************
`define UGC_CTRL_MODE        2:0
`define UGC_CTRL_SCALE       6:4
`define UGC_CTRL_RUN         8
`define UGC_CTRL_CLEAR       9
`define UGC_STAT_GATE        0
`define UGC_STAT_BUSY        1
`define UGC_STAT_NEW         2

// ****************************************
// structure and reset values
// ****************************************
`define UGC_DIV_STAGES       8
`define UGC_DIGIT_MAX        4'h9
`define UGC_LFSR_SEED        16'hACE1
`define UGC_LFSR_TAPS        16'hB400

`endif

// ===== src/ugc_pkg.sv
`default_nettype none

package ugc_pkg;

    typedef enum logic [2:0] {
        MODE_FREQ,
        MODE_PERIOD,
        MODE_PERIOD_AVG,
        MODE_RATIO,
        MODE_INTERVAL,
        MODE_INTERVAL_AVG,
        MODE_TOTALIZE,
        MODE_CHECK
    } mode_e;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ARM,
        ST_OPEN,
        ST_XFER,
        ST_TOTAL
    } state_e;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_s;

    typedef struct packed {
        state_e      st;
        mode_e       mode;
        logic [2:0]  scale;
        logic        run;
        logic        gate;
        logic        newData;
        logic        divClear;
        logic [31:0] acc;
        logic [31:0] disp;
        logic [2:0]  dp;
        logic [7:0]  phase;
        logic        tick;
        logic [15:0] lfsr;
        logic        scaled;
        apb_rsp_s    rsp;
    } core_s;

endpackage

`default_nettype wire

// ===== src/edge_sync.sv
`timescale 1ns/100ps
`default_nettype none

module edge_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             clock,
    input  wire logic             srst,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] risePulse
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] level;
        logic [WIDTH-1:0] rise;
    } sync_s;

    sync_s q_reg;
    sync_s q_next;

    // level only moves once stages two and three agree
    always_comb begin
        q_next       = q_reg;
        q_next.s1    = pinIn;
        q_next.s2    = q_reg.s1;
        q_next.s3    = q_reg.s2;
        q_next.level = (q_reg.s2 & q_reg.s3)
                     | (q_reg.level & (q_reg.s2 | q_reg.s3));
        q_next.rise  = q_next.level & ~q_reg.level;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            q_reg <= '0;
        end else if (ce) begin
            q_reg <= q_next;
        end
    end

    assign risePulse = q_reg.rise;

endmodule

`default_nettype wire

// ===== src/decade_divider.sv
`timescale 1ns/100ps
`default_nettype none
`include "ugc_regs.svh"

module decade_divider #(
    parameter int STAGES = `UGC_DIV_STAGES
) (
    input  wire logic       clock,
    input  wire logic       srst,
    input  wire logic       ce,
    input  wire logic       clear,
    input  wire logic       inPulse,
    input  wire logic [2:0] scale,
    output logic            outPulse
);

    typedef struct packed {
        logic [STAGES-1:0][3:0] dig;
        logic                   out;
    } div_s;

    div_s                   q_reg;
    div_s                   q_next;
    logic [STAGES:0]        carry;
    logic [STAGES-1:0][3:0] digNext;

    assign carry[0] = inPulse;

    // one divide-by-ten stage per decade
    for (genvar i = 0; i < STAGES; i++) begin : g_stage
        assign carry[i+1] = carry[i] & (q_reg.dig[i] == `UGC_DIGIT_MAX);
        assign digNext[i] = !carry[i] ? q_reg.dig[i]
                          : (q_reg.dig[i] == `UGC_DIGIT_MAX) ? 4'h0
                          : q_reg.dig[i] + 4'h1;
    end

    always_comb begin
        q_next     = q_reg;
        q_next.dig = clear ? '0 : digNext;
        q_next.out = ~clear & carry[scale];
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            q_reg <= '0;
        end else if (ce) begin
            q_reg <= q_next;
        end
    end

    assign outPulse = q_reg.out;

endmodule

`default_nettype wire

// ===== src/universal_gated_counter_core.sv
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "ugc_regs.svh"

module universal_gated_counter_core #(
    parameter bit HIRES = 1'b0
) (
    input  wire logic             clock,
    input  wire logic             srst,
    input  wire logic             ce,
    input  wire ugc_pkg::apb_req_s apbReq,
    output var  ugc_pkg::apb_rsp_s apbRsp,
    input  wire logic             chanA,
    input  wire logic             chanB,
    output logic [31:0]           displayValue,
    output logic [2:0]            decimalPoint,
    output logic                  gateOpen,
    output logic                  scaledOut
);
    import ugc_pkg::*;

    // ****************************************
    // time base rates
    // ****************************************
    localparam int TB_STEP_I = `UGC_NS_PER_US / `UGC_TB_PERIOD_NS;
    localparam int HR_STEP_I = `UGC_NS_PER_US / `UGC_HR_PERIOD_NS;
    localparam logic [7:0] TB_STEP = 8'(TB_STEP_I);
    localparam logic [7:0] HR_STEP = 8'(HR_STEP_I);
    localparam logic [7:0] STEP    = HIRES ? HR_STEP : TB_STEP;

    core_s q_reg;
    core_s q_next;

    logic [1:0] chanRise;
    logic       aPulse;
    logic       bPulse;
    logic       divIn;
    logic       divOut;
    logic [2:0] divScale;
    logic       openEv;
    logic       closeEv;
    logic       cntEv;
    logic       wrStb;
    logic       rdStb;
    logic       addrOk;
    logic [31:0] ctrlWord;
    logic [31:0] statWord;
    logic [8:0]  phaseSum;
    logic [7:0]  stepNow;

    // ****************************************
    // input conditioning
    // ****************************************
    edge_sync #(
        .WIDTH (2)
    ) u_sync (
        .clock     (clock),
        .srst      (srst),
        .ce        (ce),
        .pinIn     ({chanB, chanA}),
        .risePulse (chanRise)
    );

    assign aPulse = chanRise[0];
    assign bPulse = chanRise[1];

    // ****************************************
    // event routing per mode
    // ****************************************
    always_comb begin
        divIn    = aPulse;
        divScale = q_reg.scale;
        openEv   = divOut;
        closeEv  = divOut;
        cntEv    = q_reg.tick;
        case (q_reg.mode)
            MODE_FREQ: begin
                divIn = q_reg.tick;
                cntEv = aPulse;
            end
            MODE_CHECK: begin
                divIn = q_reg.tick;
            end
            MODE_PERIOD: begin
                divScale = 3'h0;
            end
            MODE_PERIOD_AVG: begin
                divIn = aPulse;
            end
            MODE_RATIO: begin
                cntEv = bPulse;
            end
            MODE_INTERVAL: begin
                openEv  = aPulse;
                closeEv = bPulse;
            end
            MODE_INTERVAL_AVG: begin
                // divider counts completed intervals
                divIn   = bPulse & q_reg.gate;
                openEv  = aPulse;
                closeEv = bPulse;
            end
            MODE_TOTALIZE: begin
                cntEv = divOut;
            end
            default: begin
                divIn = aPulse;
            end
        endcase
    end

    decade_divider #(
        .STAGES (`UGC_DIV_STAGES)
    ) u_div (
        .clock    (clock),
        .srst     (srst),
        .ce       (ce),
        .clear    (q_reg.divClear),
        .inPulse  (divIn),
        .scale    (divScale),
        .outPulse (divOut)
    );

    // ****************************************
    // register access
    // ****************************************
    assign wrStb  = apbReq.psel & apbReq.penable & apbReq.pwrite
                  & q_reg.rsp.pready;
    assign rdStb  = apbReq.psel & apbReq.penable & ~apbReq.pwrite
                  & q_reg.rsp.pready;
    assign addrOk = (apbReq.paddr == `UGC_ADDR_CTRL)
                  | (apbReq.paddr == `UGC_ADDR_STATUS)
                  | (apbReq.paddr == `UGC_ADDR_DISPLAY)
                  | (apbReq.paddr == `UGC_ADDR_ACCUM)
                  | (apbReq.paddr == `UGC_ADDR_DPOINT);

    always_comb begin
        ctrlWord                 = '0;
        ctrlWord[`UGC_CTRL_MODE]  = q_reg.mode;
        ctrlWord[`UGC_CTRL_SCALE] = q_reg.scale;
        ctrlWord[`UGC_CTRL_RUN]   = q_reg.run;
        statWord                 = '0;
        statWord[`UGC_STAT_GATE]  = q_reg.gate;
        statWord[`UGC_STAT_BUSY]  = (q_reg.st != ST_IDLE);
        statWord[`UGC_STAT_NEW]   = q_reg.newData;
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        q_next          = q_reg;
        q_next.divClear = 1'b0;
        q_next.scaled   = 1'b0;

        // ****************************************
        // counted clock
        // ****************************************
        // phase accumulator gives the counted clock as a tick enable
        stepNow = STEP;
        if (HIRES && q_reg.mode == MODE_INTERVAL_AVG) begin
            // balanced dither keeps the mean rate exact
            if (q_reg.lfsr[0]) begin
                stepNow = STEP + `UGC_DITHER;
            end else begin
                stepNow = STEP - `UGC_DITHER;
            end
        end
        phaseSum = {1'b0, q_reg.phase} + {1'b0, stepNow};
        if (phaseSum >= {1'b0, `UGC_CLK_MHZ}) begin
            q_next.phase = 8'(phaseSum - {1'b0, `UGC_CLK_MHZ});
            q_next.tick  = 1'b1;
        end else begin
            q_next.phase = phaseSum[7:0];
            q_next.tick  = 1'b0;
        end
        // noise source runs always; only high-res averaging reads it
        if (q_reg.lfsr[0]) begin
            q_next.lfsr = (q_reg.lfsr >> 1) ^ `UGC_LFSR_TAPS;
        end else begin
            q_next.lfsr = q_reg.lfsr >> 1;
        end

        // ****************************************
        // bus slave
        // ****************************************
        // apb slave: pready on the second access cycle
        q_next.rsp.pready  = apbReq.psel & apbReq.penable
                           & ~q_reg.rsp.pready;
        q_next.rsp.pslverr = apbReq.psel & apbReq.penable
                           & ~q_reg.rsp.pready & ~addrOk;
        if (apbReq.psel & apbReq.penable & ~q_reg.rsp.pready) begin
            case (apbReq.paddr)
                `UGC_ADDR_CTRL: begin
                    q_next.rsp.prdata = ctrlWord;
                end
                `UGC_ADDR_STATUS: begin
                    q_next.rsp.prdata = statWord;
                end
                `UGC_ADDR_DISPLAY: begin
                    q_next.rsp.prdata = q_reg.disp;
                end
                `UGC_ADDR_ACCUM: begin
                    q_next.rsp.prdata = q_reg.acc;
                end
                `UGC_ADDR_DPOINT: begin
                    q_next.rsp.prdata = {29'h0, q_reg.dp};
                end
                // unmapped reads return zero beside the error flag
                default: begin
                    q_next.rsp.prdata = 32'h0;
                end
            endcase
        end

        // ****************************************
        // measurement sequencer
        // ****************************************
        case (q_reg.st)
            ST_IDLE: begin
                q_next.gate = 1'b0;
                if (q_reg.run) begin
                    q_next.acc      = '0;
                    q_next.divClear = 1'b1;
                    if (q_reg.mode == MODE_TOTALIZE) begin
                        q_next.st = ST_TOTAL;
                    end else begin
                        q_next.st = ST_ARM;
                    end
                end
            end
            ST_ARM: begin
                if (q_reg.mode == MODE_INTERVAL_AVG && divOut) begin
                    q_next.st = ST_XFER;
                end else if (openEv && !q_reg.divClear) begin
                    q_next.gate = 1'b1;
                    q_next.st   = ST_OPEN;
                end
            end
            ST_OPEN: begin
                if (cntEv && q_reg.gate) begin
                    q_next.acc = q_reg.acc + 32'h1;
                end
                if (closeEv) begin
                    q_next.gate = 1'b0;
                    // averaging rearms for the next interval
                    if (q_reg.mode == MODE_INTERVAL_AVG) begin
                        q_next.st = ST_ARM;
                    end else begin
                        q_next.st = ST_XFER;
                    end
                end
            end
            ST_XFER: begin
                q_next.disp    = q_reg.acc;
                q_next.dp      = q_reg.scale;
                q_next.newData = 1'b1;
                q_next.st      = ST_IDLE;
            end
            ST_TOTAL: begin
                q_next.gate   = 1'b1;
                q_next.scaled = divOut;
                if (cntEv) begin
                    q_next.acc = q_reg.acc + 32'h1;
                end
                q_next.disp = q_next.acc;
                if (!q_reg.run) begin
                    q_next.gate = 1'b0;
                    q_next.st   = ST_IDLE;
                end
            end
            default: begin
                q_next.st   = ST_IDLE;
                q_next.gate = 1'b0;
            end
        endcase

        // ****************************************
        // register writes
        // ****************************************
        if (wrStb && apbReq.paddr == `UGC_ADDR_CTRL) begin
            q_next.mode  = mode_e'(apbReq.pwdata[`UGC_CTRL_MODE]);
            q_next.scale = apbReq.pwdata[`UGC_CTRL_SCALE];
            q_next.run   = apbReq.pwdata[`UGC_CTRL_RUN];
            if (apbReq.pwdata[`UGC_CTRL_CLEAR]) begin
                q_next.acc      = '0;
                q_next.disp     = '0;
                q_next.gate     = 1'b0;
                q_next.divClear = 1'b1;
                q_next.st       = ST_IDLE;
            end
        end
        // a transfer in the same cycle keeps the flag set
        if (wrStb && apbReq.paddr == `UGC_ADDR_STATUS
            && apbReq.pwdata[`UGC_STAT_NEW] && q_reg.st != ST_XFER) begin
            q_next.newData = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            q_reg      <= '0;
            q_reg.st   <= ST_IDLE;
            q_reg.mode <= MODE_FREQ;
            q_reg.lfsr <= `UGC_LFSR_SEED;
        end else if (ce) begin
            q_reg <= q_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign apbRsp       = q_reg.rsp;
    assign displayValue = q_reg.disp;
    assign decimalPoint = q_reg.dp;
    assign gateOpen     = q_reg.gate;
    assign scaledOut    = q_reg.scaled;

endmodule

`default_nettype wire

// ===== verification/ugc_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "ugc_regs.svh"

module ugc_sva (
    input wire logic              clock,
    input wire logic              srst,
    input wire logic              ce,
    input wire ugc_pkg::apb_req_s apbReq,
    input wire ugc_pkg::apb_rsp_s apbRsp,
    input wire logic [31:0]       displayValue,
    input wire logic [2:0]        decimalPoint,
    input wire logic              gateOpen,
    input wire logic              scaledOut
);
    import ugc_pkg::*;
    // ****************************************
    // control shadow rebuilt from bus writes
    // ****************************************
    logic [2:0] mode_reg;
    logic [2:0] scale_reg;
    logic       ctlWr;
    logic       clrWr;

    assign ctlWr = apbReq.psel && apbReq.penable && apbReq.pwrite
                   && apbRsp.pready && apbReq.paddr == `UGC_ADDR_CTRL;
    assign clrWr = ctlWr && apbReq.pwdata[`UGC_CTRL_CLEAR];

    always_ff @(posedge clock) begin
        if (srst) begin
            mode_reg  <= 3'h0;
            scale_reg <= 3'h0;
        end else if (ctlWr) begin
            mode_reg  <= apbReq.pwdata[`UGC_CTRL_MODE];
            scale_reg <= apbReq.pwdata[`UGC_CTRL_SCALE];
        end
    end

    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge clock);
    endclocking
    default disable iff (srst);

    rst_outs_a: assert property (disable iff (1'b0)
        srst && ce |=> displayValue == 32'h0 && !gateOpen
        && decimalPoint == 3'h0 && !scaledOut)
        else $error("outputs not cleared by reset");
    ready_time_a: assert property (
        apbReq.psel && apbReq.penable && !apbRsp.pready && ce
        |=> apbRsp.pready) else $error("bus answer late");
    unmapped_err_a: assert property (
        apbRsp.pready && apbReq.paddr > `UGC_ADDR_DPOINT
        |-> apbRsp.pslverr && apbRsp.prdata == 32'h0)
        else $error("unmapped access not refused");
    clear_zero_a: assert property (
        clrWr |=> displayValue == 32'h0 && !gateOpen)
        else $error("clear did not zero display");
    disp_frozen_a: assert property (
        gateOpen && mode_reg != 3'h6 && !ctlWr |=> $stable(displayValue))
        else $error("display moved while gate open");
    dp_scale_a: assert property (
        $changed(decimalPoint) |-> decimalPoint == scale_reg)
        else $error("decimal point not the scale");
    gate_rest_a: assert property (
        $fell(gateOpen) && mode_reg != 3'h5 |-> !gateOpen ##1 !gateOpen)
        else $error("gate reopened before transfer");
    scaled_pulse_a: assert property (
        scaledOut |-> mode_reg == 3'h6 ##1 !scaledOut)
        else $error("scaled pulse outside totalize");
endmodule

bind universal_gated_counter_core ugc_sva i_sva (
    .clock, .srst, .ce, .apbReq, .apbRsp, .displayValue,
    .decimalPoint, .gateOpen, .scaledOut
);
`default_nettype wire

// ===== verification/signal_source.sv
`timescale 1ns/100ps
`default_nettype none

module signal_source (
    input  wire logic        enable,
    input  wire logic [15:0] periodNs,
    input  wire logic [15:0] delayNs,
    output logic             chanA,
    output logic             chanB
);
    // ****************************************
    // repeating start on A, stop on B
    // ****************************************
    // own ns timing, so edges drift against the counter clock
    always begin
        if (enable === 1'b1) begin
            chanA = 1'b1; // repetitive, asynchronous
            #(delayNs) chanB = 1'b1;
            #(periodNs / 2 - delayNs) chanA = 1'b0;
            #(delayNs) chanB = 1'b0;
            #(periodNs - periodNs / 2 - delayNs);
        end else begin
            chanA = 1'b0;
            chanB = 1'b0;
            #3.7;
        end
    end
endmodule
`default_nettype wire

// ===== verification/universal_gated_counter_core_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "ugc_regs.svh"

module universal_gated_counter_core_tb;
    import ugc_pkg::*;
    // ****************************************
    // design, source and helpers
    // ****************************************
    logic        clock;
    logic        srst;
    logic        ce;
    apb_req_s    apbReq;
    apb_rsp_s    apbRsp;
    logic        chanA;
    logic        chanB;
    logic [31:0] displayValue;
    logic [2:0]  decimalPoint;
    logic        gateOpen;
    logic        scaledOut;
    logic        srcOn;
    logic [15:0] periodNs;
    logic [15:0] delayNs;
    int          num_errors;
    int          total_checks;
    int          seed;
    int          pulses = 0;
    int          edgesA;

    universal_gated_counter_core #(.HIRES(1'b0)) i_dut (
        .clock, .srst, .ce, .apbReq, .apbRsp, .chanA, .chanB,
        .displayValue, .decimalPoint, .gateOpen, .scaledOut);
    signal_source i_src (.enable(srcOn), .periodNs, .delayNs,
        .chanA, .chanB);

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock) begin
        if (scaledOut === 1'b1) begin
            pulses <= pulses + 1;
        end
    end
    always @(posedge chanA) edgesA++;

    function automatic logic [31:0] pow10(input int s);
        pow10 = 32'h1;
        repeat (s) pow10 = pow10 * 10;
    endfunction
    // tolerance covers the one-count ambiguity of async edges
    function automatic logic [31:0] near(input logic [31:0] v, e,
                                         input int tol);
        near = (v + tol >= e && v <= e + tol) ? e : v;
    endfunction
    function automatic logic [31:0] ctl(input logic [2:0] m, sc,
                                        input logic run, clr);
        ctl = {22'h0, clr, run, 1'b0, sc, 1'b0, m};
    endfunction

    task automatic chk(input string what, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic err);
        int n;
        n = 0;
        apbReq <= '{1'b1, 1'b0, w, a, d};
        @(posedge clock);
        apbReq.penable <= 1'b1;
        do @(posedge clock);
        while (apbRsp.pready !== 1'b1 && n++ < 50);
        // a slave that never answers counts as a mismatch
        if (apbRsp.pready !== 1'b1) begin
            num_errors++;
        end
        q = apbRsp.prdata;
        err = apbRsp.pslverr;
        apbReq <= '0;
        @(posedge clock);
    endtask
    task automatic measure(input string name, input logic [2:0] m, sc,
                           input logic [31:0] e, input int tol);
        logic [31:0] q;
        logic        err;
        int          n;
        n = 0;
        apb(1'b1, `UGC_ADDR_CTRL, ctl(m, sc, 1'b0, 1'b1), q, err);
        apb(1'b1, `UGC_ADDR_STATUS, 32'h4, q, err);
        apb(1'b1, `UGC_ADDR_CTRL, ctl(m, sc, 1'b1, 1'b0), q, err);
        do apb(1'b0, `UGC_ADDR_STATUS, 32'h0, q, err);
        while (q[`UGC_STAT_NEW] !== 1'b1 && n++ < 4000);
        chk("new data", {31'h0, q[`UGC_STAT_NEW]}, 32'h1);
        chk(name, near(displayValue, e, tol), e);
        chk("point", {29'h0, decimalPoint}, {29'h0, sc});
        apb(1'b1, `UGC_ADDR_CTRL, ctl(m, sc, 1'b0, 1'b0), q, err);
        $display("test %s done", name);
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        // about two and a half times the expected length of the whole run
        repeat (40000) @(posedge clock);
        num_errors++;
        stop_test();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        logic [31:0] q;
        logic        err;
        logic [31:0] v;
        seed = 20;
        srst = 1'b1;
        ce = 1'b1;
        apbReq = '0;
        srcOn = 1'b0;
        delayNs = 16'd50;
        repeat (3) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        v = displayValue | {30'h0, gateOpen, scaledOut};
        chk("outputs", v, 32'h0);
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0, q, err);
            chk("reset value", q, 32'h0);
            chk("bus error", {31'h0, err}, {31'h0, i == 5});
        end
        for (int m = 0; m < 8; m++) begin
            v = $random(seed);
            apb(1'b1, `UGC_ADDR_CTRL, ctl(3'(m), v[6:4], 1'b0, 1'b0), q, err);
            apb(1'b0, `UGC_ADDR_CTRL, 32'h0, q, err);
            chk("ctrl", q, ctl(3'(m), v[6:4], 1'b0, 1'b0));
        end
        $display("test registers done");
        for (int s = 0; s < 3; s++) begin
            measure("check", MODE_CHECK, 3'(s), pow10(s), 0);
        end
        v = $random(seed);
        periodNs = 16'd150 + 16'(v[5:0]);
        srcOn = 1'b1;
        measure("freq", MODE_FREQ, 3'd2, 10000 / periodNs, 1);
        periodNs = 16'd1203;
        delayNs = 16'd503;
        measure("period", MODE_PERIOD, 3'd0, 32'd12, 1);
        measure("period avg", MODE_PERIOD_AVG, 3'd1, 32'd120, 1);
        measure("ratio", MODE_RATIO, 3'd1, 32'd10, 1);
        measure("interval", MODE_INTERVAL, 3'd0, 32'd5, 1);
        measure("avg", MODE_INTERVAL_AVG, 3'd1, 32'd50, 3);
        srcOn = 1'b0;
        repeat (200) @(posedge clock);
        periodNs = 16'd203;
        delayNs = 16'd50;
        apb(1'b1, `UGC_ADDR_CTRL, ctl(3'd6, 3'd1, 1'b0, 1'b1), q, err);
        apb(1'b1, `UGC_ADDR_CTRL, ctl(3'd6, 3'd1, 1'b1, 1'b0), q, err);
        edgesA = 0;
        srcOn = 1'b1;
        repeat (2000) @(posedge clock);
        srcOn = 1'b0;
        repeat (60) @(posedge clock);
        chk("total", displayValue, 32'(edgesA / 10));
        chk("scaled", 32'(pulses), 32'(edgesA / 10));
        $display("test totalize done");
        apb(1'b1, `UGC_ADDR_CTRL, ctl(3'd6, 3'd1, 1'b0, 1'b1), q, err);
        chk("cleared", displayValue, 32'h0);
        apb(1'b0, `UGC_ADDR_ACCUM, 32'h0, q, err);
        chk("accum", q, 32'h0);
        $display("test clear done");
        // a low enable must hold a started check run still
        apb(1'b1, `UGC_ADDR_CTRL, ctl(3'd7, 3'd0, 1'b1, 1'b0), q, err);
        ce <= 1'b0;
        repeat (100) @(posedge clock);
        chk("frozen", displayValue, 32'h0);
        ce <= 1'b1;
        repeat (100) @(posedge clock);
        chk("thawed", displayValue, pow10(0));
        $display("test enable done");
        stop_test();
    end
endmodule
`default_nettype wire
